// *** hw/msd_pkg.sv ***
// Constants for the memory space decoder
package msd_pkg;
    localparam int         CODE_BANK_BITS   = 15;
    localparam logic [1:0] CODE_BANKS_LARGE = 2'h3;
    localparam logic [7:0] SP_RESET         = 8'h07;
    localparam logic [7:0] LOWER_TOP        = 8'h7F;
    localparam logic [7:0] BIT_BASE         = 8'h20;
    localparam logic [7:0] BIT_TOP          = 8'h2F;
    localparam logic [7:0] REG_TOP          = 8'h1F;
    localparam int         BANK_LO_POS      = 3;
    localparam int         BANK_HI_POS      = 4;
    localparam int         CODE_SEL_LSB     = 0;
endpackage

// *** hw/msd_stack.sv ***
// Stack pointer with push and pop sequencing
`timescale 1ns/1ps
module msd_stack
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic       sp_wr,
    input  wire logic [7:0] sp_wdata,
    output logic      [7:0] sp_q,
    output logic      [7:0] stack_addr
);
    // Pointer update; full 8-bit wrap lets stack span all 256 bytes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sp_q <= msd_pkg::SP_RESET; // RQ17
        else if (sp_wr)
            sp_q <= sp_wdata; // RQ18
        else if (push)
            sp_q <= sp_q + 8'h01; // RQ16
        else if (pop)
            sp_q <= sp_q - 8'h01; // RQ19
    end

    // Push targets one above; pop reads the pointed location
    always_comb
    begin
        stack_addr = push ? sp_q + 8'h01 : sp_q; // RQ16 RQ19
    end

    property p_push_inc;
        @(posedge clk) disable iff (!rstn)
        (push && !sp_wr) |=> sp_q == $past(sp_q) + 8'h01;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push no inc"); // RQ16

    property p_pop_dec;
        @(posedge clk) disable iff (!rstn)
        (pop && !push && !sp_wr) |=> sp_q == $past(sp_q) - 8'h01;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop no dec"); // RQ19
endmodule

// *** hw/msd_top.sv ***
// Memory space decoder: code banking, data RAM routing, bits, stack
// How it works
// [RQ1] Instruction kind picks program or data space
// [RQ2] Program memory is 32 kB code banks
// [RQ3] Bank zero always at 0x0000-0x7FFF
// [RQ4] Selected upper bank at 0x8000-0xFFFF; code maps a select of 0 to bank 1 there instead
// [RQ5] 256 bytes internal data RAM
// [RQ6] Lower 128 bytes direct or indirect
// [RQ7] Special registers separate from upper RAM
// [RQ8] Direct above 0x7F goes to special registers
// [RQ9] Indirect above 0x7F goes to upper RAM
// [RQ10] 0x00-0x1F are four eight-register banks
// [RQ11] Status word bits 3,4 select bank
// [RQ12] First two bank registers are pointers
// [RQ13] 0x20-0x2F bytes also 128 bits
// [RQ14] Bit address is 8*offset plus bit
// [RQ15] Operand type alone picks bit access
// [RQ16] Push writes pointer+1 then increments
// [RQ17] Stack pointer resets to 0x07
// [RQ18] Stack anywhere, up to 256 deep
// [RQ19] Pop reads pointer then decrements
`timescale 1ns/1ps
module msd_top
#(
    parameter int         NUM_CODE_BANKS = 4,
    parameter logic [1:0] MAX_BANK       = msd_pkg::CODE_BANKS_LARGE
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        req,
    input  wire logic        is_code,
    input  wire logic [15:0] code_addr,
    input  wire logic [1:0]  code_bank_select_register,
    input  wire logic        is_indirect,
    input  wire logic        ptr_sel,
    input  wire logic [7:0]  direct_addr,
    input  wire logic        is_bit,
    input  wire logic [6:0]  bit_addr,
    input  wire logic [7:0]  program_status_word,
    input  wire logic [7:0]  index_register_zero,
    input  wire logic [7:0]  index_register_one,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic        sp_wr,
    input  wire logic [7:0]  sp_wdata,
    output logic             code_sel_q,
    output logic [16:0]      code_phys_q,
    output logic             ram_sel_q,
    output logic             special_function_registers_sel_q,
    output logic [7:0]       data_addr_q,
    output logic             bit_access_q,
    output logic [2:0]       bit_pos_q,
    output logic [7:0]       pointer_addr_q,
    output logic [1:0]       active_bank_q,
    output logic [7:0]       stack_pointer_q,
    output logic [7:0]       stack_addr_q
);
    logic [1:0]  bank_d;
    logic [1:0]  upper_bank;
    logic [16:0] code_phys_d;
    logic [7:0]  ptr_d;
    logic [7:0]  byte_addr_d;
    logic        ram_d;
    logic        sfr_d;
    logic [7:0]  sp_cur;
    logic [7:0]  stk_addr;

    msd_stack u_stack
    (
        .clk        (clk),
        .rstn       (rstn),
        .push       (push),
        .pop        (pop),
        .sp_wr      (sp_wr),
        .sp_wdata   (sp_wdata),
        .sp_q       (sp_cur),
        .stack_addr (stk_addr)
    );

    // Working register bank from status word
    always_comb
    begin
        bank_d = {program_status_word[msd_pkg::BANK_HI_POS],
                  program_status_word[msd_pkg::BANK_LO_POS]}; // RQ11
    end

    // Select 0 maps to bank 1; numbers above MAX_BANK clamp to the top bank on small parts
    always_comb
    begin
        upper_bank = code_bank_select_register;
        if (upper_bank == 2'h0)
            upper_bank = 2'h1;
        if (upper_bank > MAX_BANK)
            upper_bank = MAX_BANK; // RQ2
    end

    // Code address to flat 32 kB bank image
    always_comb
    begin
        if (!code_addr[15])
            code_phys_d = {2'h0, code_addr[14:0]}; // RQ3
        else
            code_phys_d = {upper_bank, code_addr[14:0]}; // RQ4 RQ2
    end

    // Indirect pointer from first two registers of active bank
    always_comb
    begin
        ptr_d = ptr_sel ? index_register_one : index_register_zero; // RQ12
    end

    // Byte address and space routing
    always_comb
    begin
        byte_addr_d = 8'h00;
        ram_d = 1'b0;
        sfr_d = 1'b0;
        if (is_bit)
        begin
            // Bit area lower half only; upper bit space left to registers
            byte_addr_d = msd_pkg::BIT_BASE + {4'h0, bit_addr[6:3]}; // RQ14
            ram_d = 1'b1; // RQ13 RQ15
        end
        else if (is_indirect)
        begin
            byte_addr_d = ptr_d;
            ram_d = 1'b1; // RQ9 RQ6
        end
        else if (direct_addr > msd_pkg::LOWER_TOP)
        begin
            byte_addr_d = direct_addr;
            sfr_d = 1'b1; // RQ8 RQ7
        end
        else
        begin
            byte_addr_d = direct_addr;
            ram_d = 1'b1; // RQ6 RQ5
        end
    end

    // Registered access decode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            code_sel_q <= 1'b0;
            code_phys_q <= 17'h00000;
            ram_sel_q <= 1'b0;
            special_function_registers_sel_q <= 1'b0;
            data_addr_q <= 8'h00;
            bit_access_q <= 1'b0;
            bit_pos_q <= 3'h0;
        end
        else
        begin
            code_sel_q <= req && is_code; // RQ1
            code_phys_q <= code_phys_d;
            ram_sel_q <= req && !is_code && ram_d; // RQ1
            special_function_registers_sel_q <= req && !is_code && sfr_d;
            data_addr_q <= byte_addr_d;
            bit_access_q <= req && !is_code && is_bit; // RQ15
            bit_pos_q <= bit_addr[2:0]; // RQ14
        end
    end

    // Bank and pointer tracking
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_bank_q <= 2'h0;
            pointer_addr_q <= 8'h00;
        end
        else
        begin
            active_bank_q <= bank_d; // RQ10 RQ11
            pointer_addr_q <= ptr_d; // RQ12
        end
    end

    // Stack outputs registered so every output is a flop
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stack_pointer_q <= msd_pkg::SP_RESET; // RQ17
            stack_addr_q <= 8'h00;
        end
        else
        begin
            stack_pointer_q <= sp_cur;
            stack_addr_q <= stk_addr; // RQ16
        end
    end

    sequence s_direct_high;
        req && !is_code && !is_bit && !is_indirect
            && direct_addr > msd_pkg::LOWER_TOP;
    endsequence

    property p_direct_sfr;
        @(posedge clk) disable iff (!rstn)
        s_direct_high |=> special_function_registers_sel_q && !ram_sel_q;
    endproperty
    a_direct_sfr: assert property (p_direct_sfr) else $error("direct"); // RQ8

    property p_indirect_ram;
        @(posedge clk) disable iff (!rstn)
        (req && !is_code && !is_bit && is_indirect) |=>
            ram_sel_q && !special_function_registers_sel_q
            && data_addr_q == $past(ptr_d);
    endproperty
    a_indirect_ram: assert property (p_indirect_ram) else $error("ind"); // RQ9

    property p_bank0;
        @(posedge clk) disable iff (!rstn)
        (req && is_code && !code_addr[15]) |=>
            code_phys_q == {2'h0, $past(code_addr[14:0])};
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank zero"); // RQ3

    property p_upper;
        @(posedge clk) disable iff (!rstn)
        (req && is_code && code_addr[15] && code_bank_select_register != 2'h0)
            |=> code_phys_q[16:15] != 2'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bank"); // RQ4

    property p_bitmap;
        @(posedge clk) disable iff (!rstn)
        (req && !is_code && is_bit) |=>
            data_addr_q == msd_pkg::BIT_BASE + {4'h0, $past(bit_addr[6:3])}
            && bit_access_q && data_addr_q <= msd_pkg::BIT_TOP;
    endproperty
    a_bitmap: assert property (p_bitmap) else $error("bit map"); // RQ14

    property p_space_excl;
        @(posedge clk) disable iff (!rstn)
        !(code_sel_q && (ram_sel_q || special_function_registers_sel_q));
    endproperty
    a_space_excl: assert property (p_space_excl) else $error("space"); // RQ1

    property p_bank;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> active_bank_q == {$past(program_status_word[4]),
                                   $past(program_status_word[3])};
    endproperty
    a_bank: assert property (p_bank) else $error("reg bank"); // RQ11

    property p_sp_reset;
        @(posedge clk) $rose(rstn) |-> stack_pointer_q == 8'h07;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp reset"); // RQ17

    // Lower-half direct accesses stay in RAM
    sequence s_direct_low;
        req && !is_code && !is_bit && !is_indirect
            && direct_addr <= msd_pkg::LOWER_TOP;
    endsequence

    property p_direct_ram;
        @(posedge clk) disable iff (!rstn)
        s_direct_low |=> ram_sel_q && !special_function_registers_sel_q
            && data_addr_q == $past(direct_addr);
    endproperty
    a_direct_ram: assert property (p_direct_ram) else $error("dram"); // RQ6

    // Both selects high at once would merge the two spaces
    property p_sfr_apart;
        @(posedge clk) disable iff (!rstn)
        !(ram_sel_q && special_function_registers_sel_q);
    endproperty
    a_sfr_apart: assert property (p_sfr_apart) else $error("apart"); // RQ7

    property p_sfr_addr;
        @(posedge clk) disable iff (!rstn)
        s_direct_high |=> data_addr_q == $past(direct_addr);
    endproperty
    a_sfr_addr: assert property (p_sfr_addr) else $error("sfr addr"); // RQ8

    sequence s_code_req;
        req && is_code;
    endsequence

    property p_code_only;
        @(posedge clk) disable iff (!rstn)
        s_code_req |=> code_sel_q && !ram_sel_q && !bit_access_q
            && !special_function_registers_sel_q;
    endproperty
    a_code_only: assert property (p_code_only) else $error("code"); // RQ1

    // No strobe without a request
    property p_idle;
        @(posedge clk) disable iff (!rstn)
        !req |=> !code_sel_q && !ram_sel_q && !bit_access_q
            && !special_function_registers_sel_q;
    endproperty
    a_idle: assert property (p_idle) else $error("idle"); // RQ1

    property p_upper_exact;
        @(posedge clk) disable iff (!rstn)
        (req && is_code && code_addr[15] && code_bank_select_register != 2'h0
            && code_bank_select_register <= MAX_BANK) |=>
            code_phys_q == {$past(code_bank_select_register),
                            $past(code_addr[14:0])};
    endproperty
    a_upper_exact: assert property (p_upper_exact) else $error("ubank"); // RQ4

    // Small variant folds missing banks onto its top bank
    property p_upper_clamp;
        @(posedge clk) disable iff (!rstn)
        (req && is_code && code_addr[15]
            && code_bank_select_register > MAX_BANK)
            |=> code_phys_q[16:15] == MAX_BANK;
    endproperty
    a_upper_clamp: assert property (p_upper_clamp) else $error("clamp"); // RQ2

    property p_bank_count;
        @(posedge clk) disable iff (!rstn)
        code_sel_q |-> code_phys_q[16:15] <= MAX_BANK
            && code_phys_q[16:15] < NUM_CODE_BANKS;
    endproperty
    a_bank_count: assert property (p_bank_count) else $error("count"); // RQ2

    property p_bit_pos;
        @(posedge clk) disable iff (!rstn)
        (req && !is_code && is_bit) |=> bit_pos_q == $past(bit_addr[2:0])
            && ram_sel_q && !special_function_registers_sel_q;
    endproperty
    a_bit_pos: assert property (p_bit_pos) else $error("bit pos"); // RQ13

    // Push lands one above the pointer, which then follows
    sequence s_push_land;
        (stack_addr_q == stack_pointer_q + 8'h01)
            ##1 (stack_pointer_q == $past(stack_addr_q));
    endsequence

    property p_push_seq;
        @(posedge clk) disable iff (!rstn)
        (push && !sp_wr) |=> s_push_land;
    endproperty
    a_push_seq: assert property (p_push_seq) else $error("push seq"); // RQ16

    sequence s_pop_land;
        (stack_addr_q == stack_pointer_q)
            ##1 (stack_pointer_q == $past(stack_addr_q) - 8'h01);
    endsequence

    property p_pop_seq;
        @(posedge clk) disable iff (!rstn)
        (pop && !push && !sp_wr) |=> s_pop_land;
    endproperty
    a_pop_seq: assert property (p_pop_seq) else $error("pop seq"); // RQ19

    property p_sp_load;
        @(posedge clk) disable iff (!rstn)
        sp_wr |-> ##2 stack_pointer_q == $past(sp_wdata, 2);
    endproperty
    a_sp_load: assert property (p_sp_load) else $error("sp load"); // RQ18
endmodule

// *** verif/msd_cpu_model.sv ***
// Execution-side model: status word and index registers
`timescale 1ns/1ps
module msd_cpu_model
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       load,
    input  wire logic [7:0] psw_in,
    input  wire logic [7:0] idx0_in,
    input  wire logic [7:0] idx1_in,
    output logic      [7:0] psw_q,
    output logic      [7:0] idx0_q,
    output logic      [7:0] idx1_q
);
    // Rising edge, so the decoder sees the new state one edge later
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            psw_q  <= 8'h00;
            idx0_q <= 8'h00;
            idx1_q <= 8'h00;
        end
        else if (load)
        begin
            psw_q  <= psw_in;
            idx0_q <= idx0_in;
            idx1_q <= idx1_in;
        end
    end
endmodule

// *** verif/msd_top_tb.sv ***
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
module msd_top_tb;
    logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, is_code = 1'b0;
    logic        is_indirect = 1'b0, ptr_sel = 1'b0, is_bit = 1'b0;
    logic        push = 1'b0, pop = 1'b0, sp_wr = 1'b0, load = 1'b0;
    logic [15:0] code_addr = 16'h0000;
    logic [1:0]  code_bank_select_register = 2'h0, active_bank_q;
    logic [7:0]  direct_addr = 8'h00, sp_wdata = 8'h00, psw_in = 8'h00;
    logic [7:0]  idx0_in = 8'h00, idx1_in = 8'h00;
    logic [6:0]  bit_addr = 7'h00;
    logic [7:0]  program_status_word, index_register_zero;
    logic [7:0]  index_register_one, data_addr_q, pointer_addr_q;
    logic [7:0]  stack_pointer_q, stack_addr_q;
    logic        code_sel_q, ram_sel_q, special_function_registers_sel_q;
    logic        bit_access_q;
    logic [16:0] code_phys_q, code_phys_small;
    logic [2:0]  bit_pos_q;
    int          err_total = 0;
    int          checked = 0;

    always #12.5 clk = ~clk;

    msd_cpu_model cpu_u (.clk, .rstn, .load, .psw_in, .idx0_in, .idx1_in,
        .psw_q(program_status_word), .idx0_q(index_register_zero),
        .idx1_q(index_register_one));
    msd_top dut_u (.clk, .rstn, .req, .is_code, .code_addr,
        .code_bank_select_register, .is_indirect, .ptr_sel, .direct_addr,
        .is_bit, .bit_addr, .program_status_word, .index_register_zero,
        .index_register_one, .push, .pop, .sp_wr, .sp_wdata, .code_sel_q,
        .code_phys_q, .ram_sel_q, .special_function_registers_sel_q,
        .data_addr_q, .bit_access_q, .bit_pos_q, .pointer_addr_q,
        .active_bank_q, .stack_pointer_q, .stack_addr_q);
    // Three-bank variant, only its code mapping is compared
    msd_top #(.NUM_CODE_BANKS(3), .MAX_BANK(2'h2)) small_u (.clk, .rstn,
        .req, .is_code, .code_addr, .code_bank_select_register,
        .is_indirect, .ptr_sel, .direct_addr, .is_bit, .bit_addr,
        .program_status_word, .index_register_zero, .index_register_one,
        .push, .pop, .sp_wr, .sp_wdata, .code_sel_q(),
        .code_phys_q(code_phys_small), .ram_sel_q(),
        .special_function_registers_sel_q(), .data_addr_q(),
        .bit_access_q(), .bit_pos_q(), .pointer_addr_q(),
        .active_bank_q(), .stack_pointer_q(), .stack_addr_q());

    task automatic chk(string name, logic [16:0] seen, logic [16:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic data(logic ind, logic ps, logic b, logic [7:0] a);
        req = 1'b1;
        is_code = 1'b0;
        is_indirect = ind;
        ptr_sel = ps;
        is_bit = b;
        direct_addr = a;
        bit_addr = a[6:0];
        @(negedge clk);
    endtask

    task automatic t_reset();
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        chk("sp", stack_pointer_q, 17'h00007);
        chk("ram", ram_sel_q, 17'h00000);
    endtask

    task automatic t_code();
        logic [1:0] eb;
        logic [1:0] es;
        req = 1'b1;
        is_code = 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            code_bank_select_register = 2'(b);
            eb = (b == 0) ? 2'h1 : 2'(b);
            es = (b == 3) ? 2'h2 : eb;
            code_addr = 16'hC123;
            @(negedge clk);
            chk("csel", code_sel_q, 17'h00001);
            chk("cup", code_phys_q, {eb, 15'h4123});
            chk("csmall", code_phys_small, {es, 15'h4123});
            code_addr = 16'h7FFF;
            @(negedge clk);
            chk("clo", code_phys_q, {2'h0, 15'h7FFF});
            chk("cslo", code_phys_small, {2'h0, 15'h7FFF});
        end
    endtask

    task automatic t_data();
        for (int b = 0; b < 4; b++)
        begin
            psw_in = 8'hE7 | 8'(b << 3);
            idx0_in = 8'h45;
            idx1_in = 8'h90;
            load = 1'b1;
            @(negedge clk);
            load = 1'b0;
            data(1'b0, 1'b0, 1'b0, 8'h45);
            chk("csel", code_sel_q, 17'h00000);
            chk("dram", ram_sel_q, 17'h00001);
            chk("dadr", data_addr_q, 17'h00045);
            data(1'b0, 1'b0, 1'b0, 8'h80);
            chk("dsfr", special_function_registers_sel_q, 17'h1);
            chk("dnram", ram_sel_q, 17'h00000);
            data(1'b1, 1'b0, 1'b0, 8'h00);
            chk("i0", data_addr_q, 17'h00045);
            chk("p0", pointer_addr_q, 17'h00045);
            chk("bank", active_bank_q, 17'(b));
            data(1'b1, 1'b1, 1'b0, 8'h00);
            chk("iram", ram_sel_q, 17'h00001);
            chk("isfr", special_function_registers_sel_q, 17'h0);
            chk("i1", data_addr_q, 17'h00090);
            chk("p1", pointer_addr_q, 17'h00090);
        end
    endtask

    task automatic t_bit();
        data(1'b1, 1'b0, 1'b1, 8'h13);
        chk("bacc", bit_access_q, 17'h00001);
        chk("bbyte", data_addr_q, 17'h00022);
        chk("bpos", bit_pos_q, 17'h00003);
        data(1'b0, 1'b0, 1'b1, 8'h7F);
        chk("btop", data_addr_q, 17'h0002F);
        chk("bpos7", bit_pos_q, 17'h00007);
        data(1'b0, 1'b0, 1'b0, 8'h22);
        chk("byte", bit_access_q, 17'h00000);
    endtask

    task automatic t_stack();
        req = 1'b0;
        push = 1'b1;
        @(negedge clk);
        push = 1'b0;
        chk("idle", ram_sel_q, 17'h00000);
        chk("pushat", stack_addr_q, 17'h00008);
        chk("splag", stack_pointer_q, 17'h00007);
        @(negedge clk);
        chk("spinc", stack_pointer_q, 17'h00008);
        pop = 1'b1;
        @(negedge clk);
        pop = 1'b0;
        chk("popat", stack_addr_q, 17'h00008);
        @(negedge clk);
        chk("spdec", stack_pointer_q, 17'h00007);
        // Top of memory must wrap, not saturate
        sp_wr = 1'b1;
        sp_wdata = 8'hFF;
        @(negedge clk);
        sp_wr = 1'b0;
        push = 1'b1;
        @(negedge clk);
        push = 1'b0;
        chk("wrap", stack_addr_q, 17'h00000);
        @(negedge clk);
        chk("spwrap", stack_pointer_q, 17'h00000);
        // Push outranks pop, a pointer write outranks push
        push = 1'b1;
        pop = 1'b1;
        @(negedge clk);
        pop = 1'b0;
        chk("pushpop", stack_addr_q, 17'h00001);
        sp_wr = 1'b1;
        sp_wdata = 8'h30;
        @(negedge clk);
        sp_wr = 1'b0;
        push = 1'b0;
        @(negedge clk);
        chk("spwr", stack_pointer_q, 17'h00030);
    endtask

    initial
    begin
        t_reset();
        t_code();
        t_data();
        t_bit();
        t_stack();
        t_reset();
        conclude();
    end

    initial
    begin
        #(25 * 2000);
        err_total++;
        conclude();
    end
endmodule
